// ==== hdl/ltc_defines.svh ====
// Field positions, fixed values and counts of the tunnel framer
`ifndef LTC_DEFINES_SVH
`define LTC_DEFINES_SVH
`define LTC_T_BIT 7
`define LTC_L_BIT 6
`define LTC_S_BIT 3
`define LTC_VER 4'h3
`define LTC_HDR_LEN 16'h000C
`define LTC_HDR_LAST 5'h0B
`define LTC_HDR_AVP_LAST 5'h11
`define LTC_AVP_LEN 16'h0006
`define LTC_AVP_M_BIT 7
`define LTC_AVP_H_BIT 6
`define LTC_AVP_TYPE_IDX 10'h005
`define LTC_CRC_INIT 32'hFFFF_FFFF
`define LTC_CRC_POLY 32'hEDB8_8320
`define LTC_CRC_RESID 32'hDEBB_20E3
`define LTC_FCS_LEN 3'h4
`define LTC_FCS_LAST 2'h3
`define LTC_CSUM_ONES 16'hFFFF
`endif

// ==== hdl/ltc_pkg.sv ====
// Types of the tunnel framer
package ltc_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_PAY, TX_FCS} ltc_tx_state_type;
endpackage : ltc_pkg

// ==== hdl/ltc_host_framer.sv ====
// Tunnel control framer and checker with payload FIFO
//----------------------------------------------------------------
// Overview of operation
//----------------------------------------------------------------
`include "ltc_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module ltc_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output var logic in_ready,
	// Drain side
	output wire logic [W-1:0] out_data,
	output var logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(D);
	localparam int CW = $clog2(D + 1);
	generate
		if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
			$error("FIFO depth must be a power of two");
		end
	endgenerate
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic push;
	logic pop;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_reg];
	always_comb begin
		cnt_next = cnt_reg + CW'(push) - CW'(pop);
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			wr_reg <= '0;
			rd_reg <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			wr_reg <= wr_reg + AW'(push);
			rd_reg <= rd_reg + AW'(pop);
			in_ready <= cnt_next != CW'(D);
			out_valid <= cnt_next != '0;
		end
	end
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end
endmodule : ltc_fifo

module ltc_host_framer #(
	parameter logic [15:0] KNOWN_VENDOR = 16'h0A5C, // Arbitrary value
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Transmit command
	input wire logic TX_START,
	input wire logic TX_IS_CTRL,
	input wire logic TX_CSUM_EN,
	input wire logic TX_AVP_EN,
	input wire logic TX_AVP_M,
	input wire logic [15:0] TX_AVP_VENDOR,
	input wire logic [15:0] TX_AVP_TYPE,
	input wire logic [31:0] TX_CCID,
	input wire logic [15:0] TX_NS,
	input wire logic [15:0] TX_NR,
	input wire logic [15:0] TX_PAYLOAD_LEN,
	input wire logic [15:0] TX_PSEUDO_SUM,
	output var logic TX_BUSY,
	// Transmit payload
	input wire logic [7:0] TX_IN_DATA,
	input wire logic TX_IN_LAST,
	input wire logic TX_IN_VALID,
	output wire logic TX_IN_READY,
	// Transmit stream
	output var logic [7:0] TX_OUT_DATA,
	output var logic TX_OUT_LAST,
	output var logic TX_OUT_VALID,
	input wire logic TX_OUT_READY,
	output var logic [15:0] TX_CSUM,
	output var logic TX_CSUM_VALID,
	// Receive stream
	input wire logic [7:0] RX_DATA,
	input wire logic RX_LAST,
	input wire logic RX_VALID,
	input wire logic RX_IS_CTRL,
	input wire logic [15:0] RX_CSUM_FIELD,
	input wire logic [15:0] RX_PSEUDO_SUM,
	input wire logic RX_AUTH_ACTIVE,
	input wire logic RX_DATA_VERIFY,
	// Receive results
	output var logic [31:0] RX_CCID,
	output var logic [15:0] RX_NS,
	output var logic [15:0] RX_NR,
	output var logic RX_HDR_VALID,
	output var logic RX_AVP_VALID,
	output var logic RX_AVP_M,
	output var logic [15:0] RX_AVP_VENDOR,
	output var logic [15:0] RX_AVP_TYPE,
	output var logic RX_AVP_DROP,
	output var logic RX_TEARDOWN,
	output var logic RX_DONE,
	output var logic RX_OK,
	output var logic RX_BAD_CRC,
	output var logic RX_BAD_CSUM,
	output var logic RX_BAD_HDR,
	output var logic RX_BAD_LEN
);
	generate
		if (FIFO_DEPTH < 2) begin : g_chk
			$error("FIFO depth too small");
		end
	endgenerate

	//----------------------------------------------------------------
	// Shared arithmetic
	//----------------------------------------------------------------
	function automatic logic [31:0] crc8(input logic [31:0] c,
		input logic [7:0] b);
		logic [31:0] r;
		r = c ^ {24'h00_0000, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `LTC_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc8

	function automatic logic [15:0] cadd(input logic [15:0] a,
		input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction : cadd

	// Odd trailing byte is padded with zero in the low half
	function automatic logic [15:0] fsum(input logic [15:0] s,
		input logic p, input logic [7:0] h, input logic [15:0] ps);
		logic [15:0] r;
		r = p ? cadd(s, {h, 8'h00}) : s;
		return cadd(r, ps);
	endfunction : fsum

	//----------------------------------------------------------------
	// Transmit
	//----------------------------------------------------------------
	ltc_pkg::ltc_tx_state_type st_reg;
	logic ctrl_reg;
	logic csen_reg;
	logic avp_reg;
	logic m_reg;
	logic [15:0] ven_reg;
	logic [15:0] typ_reg;
	logic [31:0] ccid_reg;
	logic [15:0] ns_reg;
	logic [15:0] nr_reg;
	logic [15:0] plen_reg;
	logic [15:0] psum_reg;
	logic [4:0] hidx_reg;
	logic [1:0] fidx_reg;
	logic [31:0] crc_reg;
	logic [15:0] sum_reg;
	logic pend_reg;
	logic [7:0] hi_reg;
	logic [8:0] f_data;
	logic f_valid;
	logic adv;
	logic emit;
	logic pop;
	logic feed;
	logic [7:0] ob;
	logic ol;
	logic [7:0] hb;
	logic [15:0] mlen;
	logic [9:0] alen;
	logic [15:0] tcs;

	ltc_fifo #(.W(9), .D(FIFO_DEPTH)) u_fifo (
		.clk(CLK),
		.rst_n(RST_N),
		.in_data({TX_IN_LAST, TX_IN_DATA}),
		.in_valid(TX_IN_VALID),
		.in_ready(TX_IN_READY),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(pop)
	);

	assign adv = !TX_OUT_VALID || TX_OUT_READY;

	always_comb begin
		mlen = `LTC_HDR_LEN + (avp_reg ? `LTC_AVP_LEN : 16'h0000) + plen_reg;
		alen = 10'(plen_reg + `LTC_AVP_LEN);
		hb = 8'h00;
		unique case (hidx_reg)
			5'h00: begin
				hb[`LTC_T_BIT] = 1'b1;
				hb[`LTC_L_BIT] = 1'b1;
				hb[`LTC_S_BIT] = 1'b1;
			end
			5'h01: hb = {4'h0, `LTC_VER};
			5'h02: hb = mlen[15:8];
			5'h03: hb = mlen[7:0];
			5'h04: hb = ccid_reg[31:24];
			5'h05: hb = ccid_reg[23:16];
			5'h06: hb = ccid_reg[15:8];
			5'h07: hb = ccid_reg[7:0];
			5'h08: hb = ns_reg[15:8];
			5'h09: hb = ns_reg[7:0];
			5'h0A: hb = nr_reg[15:8];
			5'h0B: hb = nr_reg[7:0];
			5'h0C: hb = {m_reg, 5'h00, alen[9:8]};
			5'h0D: hb = alen[7:0];
			5'h0E: hb = ven_reg[15:8];
			5'h0F: hb = ven_reg[7:0];
			5'h10: hb = typ_reg[15:8];
			5'h11: hb = typ_reg[7:0];
			default: hb = 8'h00;
		endcase
	end

	always_comb begin
		emit = 1'b0;
		pop = 1'b0;
		ob = hb;
		ol = 1'b0;
		unique case (st_reg)
			ltc_pkg::TX_IDLE: emit = 1'b0;
			ltc_pkg::TX_HDR: emit = adv;
			ltc_pkg::TX_PAY: begin
				emit = adv && f_valid;
				pop = emit;
				ob = f_data[7:0];
			end
			ltc_pkg::TX_FCS: begin
				emit = adv;
				ob = 8'((~crc_reg) >> {fidx_reg, 3'h0});
				ol = fidx_reg == `LTC_FCS_LAST;
			end
		endcase
		feed = emit && st_reg != ltc_pkg::TX_FCS;
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			st_reg <= ltc_pkg::TX_IDLE;
			TX_BUSY <= 1'b0;
			hidx_reg <= 5'h00;
			fidx_reg <= 2'h0;
		end else begin
			unique case (st_reg)
				ltc_pkg::TX_IDLE: begin
					if (TX_START) begin
						st_reg <= TX_IS_CTRL ? ltc_pkg::TX_HDR : ltc_pkg::TX_PAY;
						TX_BUSY <= 1'b1;
						hidx_reg <= 5'h00;
						fidx_reg <= 2'h0;
					end
				end
				ltc_pkg::TX_HDR: begin
					if (emit) begin
						hidx_reg <= hidx_reg + 5'h01;
						if (hidx_reg == (avp_reg ? `LTC_HDR_AVP_LAST : `LTC_HDR_LAST)) begin
							st_reg <= ltc_pkg::TX_PAY;
						end
					end
				end
				ltc_pkg::TX_PAY: begin
					if (emit && f_data[8]) begin
						st_reg <= ltc_pkg::TX_FCS;
					end
				end
				ltc_pkg::TX_FCS: begin
					if (emit) begin
						fidx_reg <= fidx_reg + 2'h1;
						if (ol) begin
							st_reg <= ltc_pkg::TX_IDLE;
							TX_BUSY <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ctrl_reg <= 1'b0;
			csen_reg <= 1'b0;
			avp_reg <= 1'b0;
			m_reg <= 1'b0;
			ven_reg <= 16'h0000;
			typ_reg <= 16'h0000;
			ccid_reg <= 32'h0000_0000;
			ns_reg <= 16'h0000;
			nr_reg <= 16'h0000;
			plen_reg <= 16'h0000;
			psum_reg <= 16'h0000;
		end else if (st_reg == ltc_pkg::TX_IDLE && TX_START) begin
			ctrl_reg <= TX_IS_CTRL;
			csen_reg <= TX_CSUM_EN;
			avp_reg <= TX_AVP_EN && TX_IS_CTRL;
			m_reg <= TX_AVP_M;
			ven_reg <= TX_AVP_VENDOR;
			typ_reg <= TX_AVP_TYPE;
			ccid_reg <= TX_CCID;
			ns_reg <= TX_NS;
			nr_reg <= TX_NR;
			plen_reg <= TX_PAYLOAD_LEN;
			psum_reg <= TX_PSEUDO_SUM;
		end
	end

	// Running CRC and checksum over message bytes
	always_ff @(posedge CLK) begin
		if (!RST_N || (st_reg == ltc_pkg::TX_IDLE && TX_START)) begin
			crc_reg <= `LTC_CRC_INIT;
			sum_reg <= 16'h0000;
			pend_reg <= 1'b0;
			hi_reg <= 8'h00;
		end else if (feed) begin
			crc_reg <= crc8(crc_reg, ob);
			pend_reg <= !pend_reg;
			hi_reg <= ob;
			if (pend_reg) begin
				sum_reg <= cadd(sum_reg, {hi_reg, ob});
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			TX_OUT_VALID <= 1'b0;
			TX_OUT_DATA <= 8'h00;
			TX_OUT_LAST <= 1'b0;
		end else if (adv) begin
			TX_OUT_VALID <= emit;
			TX_OUT_DATA <= ob;
			TX_OUT_LAST <= ol;
		end
	end

	assign tcs = ~fsum(sum_reg, pend_reg, hi_reg, psum_reg);

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			TX_CSUM <= 16'h0000;
			TX_CSUM_VALID <= 1'b0;
		end else begin
			TX_CSUM_VALID <= st_reg == ltc_pkg::TX_FCS && emit && fidx_reg == 2'h0;
			if (!ctrl_reg && !csen_reg) begin
				TX_CSUM <= 16'h0000;
			end else if (tcs == 16'h0000) begin
				TX_CSUM <= `LTC_CSUM_ONES;
			end else begin
				TX_CSUM <= tcs;
			end
		end
	end

	sequence ctrl_start_s;
		st_reg == ltc_pkg::TX_IDLE && TX_START && TX_IS_CTRL && !TX_OUT_VALID;
	endsequence

	sequence first_byte_s;
		TX_OUT_VALID && TX_OUT_DATA[`LTC_T_BIT] && TX_OUT_DATA[`LTC_L_BIT];
	endsequence

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	ctrl_csum_nonzero_a: assert property (TX_CSUM_VALID && ctrl_reg |-> TX_CSUM != 16'h0000) else $error("Control checksum is zero");
	data_csum_zero_a: assert property (TX_CSUM_VALID && !ctrl_reg && !csen_reg |-> TX_CSUM == 16'h0000) else $error("Disabled data checksum not zero");
	hdr_flags_a: assert property (ctrl_start_s ##2 1'b1 |-> first_byte_s and TX_OUT_DATA[`LTC_S_BIT]) else $error("Header flag bits wrong");
	hdr_len_a: assert property (st_reg == ltc_pkg::TX_HDR && emit && hidx_reg == 5'h03 |=> TX_OUT_DATA == mlen[7:0]) else $error("Header length byte wrong");
	fcs_tail_a: assert property (TX_OUT_VALID && $rose(TX_OUT_LAST) |-> $past(st_reg) == ltc_pkg::TX_FCS) else $error("Frame ended without CRC");

	//----------------------------------------------------------------
	// Receive
	//----------------------------------------------------------------
	logic infr_reg;
	logic fin_reg;
	logic rctl_reg;
	logic [15:0] rcnt_reg;
	logic [31:0] rcrc_reg;
	logic [7:0] d_reg [4];
	logic [2:0] dcnt_reg;
	logic [2:0] dcnt_b;
	logic ex_v;
	logic [7:0] e;
	logic [15:0] ridx_reg;
	logic [15:0] rlen_reg;
	logic [9:0] aidx_reg;
	logic [9:0] alen_reg;
	logic am_reg;
	logic ah_reg;
	logic [7:0] th_reg;
	logic bad_hdr_reg;
	logic [15:0] rsum_reg;
	logic rpend_reg;
	logic [7:0] rhi_reg;
	logic rstart;
	logic in_avp;
	logic unknown;
	logic cs_ok;
	logic bad_cs;
	logic bad_crc;
	logic bad_len;

	assign rstart = RX_VALID && !infr_reg;
	assign dcnt_b = infr_reg ? dcnt_reg : 3'h0;
	assign ex_v = RX_VALID && dcnt_b == `LTC_FCS_LEN;
	assign e = d_reg[3];
	assign in_avp = rctl_reg && ridx_reg >= `LTC_HDR_LEN;
	assign unknown = RX_AVP_VENDOR != 16'h0000 && RX_AVP_VENDOR != KNOWN_VENDOR;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			infr_reg <= 1'b0;
			fin_reg <= 1'b0;
			rctl_reg <= 1'b0;
			rcnt_reg <= 16'h0000;
			rcrc_reg <= `LTC_CRC_INIT;
			dcnt_reg <= 3'h0;
		end else begin
			fin_reg <= RX_VALID && RX_LAST;
			if (RX_VALID) begin
				infr_reg <= !RX_LAST;
				rcnt_reg <= (infr_reg ? rcnt_reg : 16'h0000) + 16'h0001;
				rcrc_reg <= crc8(infr_reg ? rcrc_reg : `LTC_CRC_INIT, RX_DATA);
				dcnt_reg <= ex_v ? dcnt_b : dcnt_b + 3'h1;
			end
			if (rstart) begin
				rctl_reg <= RX_IS_CTRL;
			end
		end
	end

	// Last four bytes are held back so the CRC is never parsed
	always_ff @(posedge CLK) begin
		if (RX_VALID) begin
			d_reg[0] <= RX_DATA;
			for (int i = 1; i < 4; i++) begin
				d_reg[i] <= d_reg[i-1];
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N || rstart) begin
			rsum_reg <= 16'h0000;
			rpend_reg <= 1'b0;
			rhi_reg <= 8'h00;
		end else if (ex_v) begin
			rpend_reg <= !rpend_reg;
			rhi_reg <= e;
			if (rpend_reg) begin
				rsum_reg <= cadd(rsum_reg, {rhi_reg, e});
			end
		end
	end

	// Header fields; reserved bits are not looked at
	always_ff @(posedge CLK) begin
		if (!RST_N || rstart) begin
			ridx_reg <= 16'h0000;
			rlen_reg <= 16'h0000;
			bad_hdr_reg <= 1'b0;
			RX_CCID <= 32'h0000_0000;
			RX_NS <= 16'h0000;
			RX_NR <= 16'h0000;
		end else if (ex_v && rctl_reg) begin
			ridx_reg <= ridx_reg + 16'h0001;
			unique case (ridx_reg)
				16'h0000: begin
					if (!e[`LTC_T_BIT] || !e[`LTC_L_BIT] || !e[`LTC_S_BIT]) begin
						bad_hdr_reg <= 1'b1;
					end
				end
				16'h0001: begin
					if (e[3:0] != `LTC_VER) begin
						bad_hdr_reg <= 1'b1;
					end
				end
				16'h0002: rlen_reg[15:8] <= e;
				16'h0003: rlen_reg[7:0] <= e;
				16'h0004: RX_CCID[31:24] <= e;
				16'h0005: RX_CCID[23:16] <= e;
				16'h0006: RX_CCID[15:8] <= e;
				16'h0007: RX_CCID[7:0] <= e;
				16'h0008: RX_NS[15:8] <= e;
				16'h0009: RX_NS[7:0] <= e;
				16'h000A: RX_NR[15:8] <= e;
				16'h000B: RX_NR[7:0] <= e;
				default: begin
					if (aidx_reg == 10'h001 && {alen_reg[9:8], e} < 10'(`LTC_AVP_LEN)) begin
						bad_hdr_reg <= 1'b1;
					end
				end
			endcase
		end
	end

	// Attribute walk; value bytes, reserved ones included, are skipped
	always_ff @(posedge CLK) begin
		if (!RST_N || rstart) begin
			aidx_reg <= 10'h000;
			alen_reg <= 10'h000;
			am_reg <= 1'b0;
			ah_reg <= 1'b0;
			th_reg <= 8'h00;
			RX_AVP_VENDOR <= 16'h0000;
		end else if (ex_v && in_avp) begin
			aidx_reg <= aidx_reg + 10'h001;
			if (aidx_reg >= `LTC_AVP_TYPE_IDX && aidx_reg + 10'h001 >= alen_reg) begin
				aidx_reg <= 10'h000;
			end
			unique case (aidx_reg)
				10'h000: begin
					am_reg <= e[`LTC_AVP_M_BIT];
					ah_reg <= e[`LTC_AVP_H_BIT];
					alen_reg[9:8] <= e[1:0];
				end
				10'h001: alen_reg[7:0] <= e;
				10'h002: RX_AVP_VENDOR[15:8] <= e;
				10'h003: RX_AVP_VENDOR[7:0] <= e;
				10'h004: th_reg <= e;
				default: th_reg <= th_reg;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			RX_HDR_VALID <= 1'b0;
			RX_AVP_VALID <= 1'b0;
			RX_AVP_DROP <= 1'b0;
			RX_TEARDOWN <= 1'b0;
			RX_AVP_M <= 1'b0;
			RX_AVP_TYPE <= 16'h0000;
		end else begin
			RX_HDR_VALID <= ex_v && rctl_reg && ridx_reg == 16'h000B;
			RX_AVP_VALID <= 1'b0;
			RX_AVP_DROP <= 1'b0;
			RX_TEARDOWN <= 1'b0;
			if (ex_v && in_avp && aidx_reg == `LTC_AVP_TYPE_IDX) begin
				RX_AVP_M <= am_reg;
				RX_AVP_TYPE <= {th_reg, e};
				if (!unknown && !ah_reg) begin
					RX_AVP_VALID <= 1'b1;
				end else if (am_reg) begin
					RX_TEARDOWN <= 1'b1;
				end else begin
					RX_AVP_DROP <= 1'b1;
				end
			end
		end
	end

	always_comb begin
		cs_ok = fsum(fsum(rsum_reg, rpend_reg, rhi_reg, RX_PSEUDO_SUM), 1'b0,
			8'h00, RX_CSUM_FIELD) == `LTC_CSUM_ONES;
		if (rctl_reg) begin
			bad_cs = RX_CSUM_FIELD == 16'h0000 ? !RX_AUTH_ACTIVE : !cs_ok;
		end else begin
			bad_cs = RX_CSUM_FIELD != 16'h0000 && RX_DATA_VERIFY && !cs_ok;
		end
		bad_crc = rcrc_reg != `LTC_CRC_RESID;
		bad_len = rctl_reg && rlen_reg != rcnt_reg - 16'h0004;
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			RX_DONE <= 1'b0;
			RX_OK <= 1'b0;
			RX_BAD_CRC <= 1'b0;
			RX_BAD_CSUM <= 1'b0;
			RX_BAD_HDR <= 1'b0;
			RX_BAD_LEN <= 1'b0;
		end else begin
			RX_DONE <= fin_reg;
			if (fin_reg) begin
				RX_BAD_CRC <= bad_crc;
				RX_BAD_CSUM <= bad_cs;
				RX_BAD_HDR <= rctl_reg && bad_hdr_reg;
				RX_BAD_LEN <= bad_len;
				RX_OK <= !bad_crc && !bad_cs && !bad_len && !(rctl_reg && bad_hdr_reg);
			end
		end
	end

	sequence avp_unknown_s;
		ex_v && in_avp && aidx_reg == `LTC_AVP_TYPE_IDX && unknown;
	endsequence

	rx_done_a: assert property (RX_VALID && RX_LAST |-> ##2 RX_DONE) else $error("Receive result missing");
	ctrl_zero_rej_a: assert property (fin_reg && rctl_reg && RX_CSUM_FIELD == 16'h0000 && !RX_AUTH_ACTIVE |=> RX_BAD_CSUM && !RX_OK) else $error("Zero control checksum accepted");
	avp_silent_drop_a: assert property (avp_unknown_s ##0 !am_reg |=> RX_AVP_DROP && !RX_TEARDOWN && !RX_AVP_VALID) else $error("Unknown optional attribute not dropped");
	avp_teardown_a: assert property (avp_unknown_s ##0 am_reg |=> RX_TEARDOWN && !RX_AVP_DROP) else $error("Mandatory attribute reject ignored");
endmodule : ltc_host_framer
`default_nettype wire

// ==== testbench/ltc_peer.sv ====
// Peer tunnel endpoint model: stalling stream sink and frame source
`timescale 1ns/10ps
`default_nettype none
`include "ltc_defines.svh"

module ltc_peer (
	// Clock
	input wire logic clk,
	// Stream from the framer
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_last,
	output var logic tx_ready,
	// Stream to the framer
	output var logic [7:0] rx_data,
	output var logic rx_valid,
	output var logic rx_last
);
	logic [7:0] got[$];
	int last_pos = 0;
	bit stall = 0;
	int cyc = 0;

	initial begin
		tx_ready = 1'b0;
		{rx_data, rx_valid, rx_last} = '0;
	end

	//--------------------
	// Stream sink
	//--------------------
	always @(negedge clk) begin
		cyc <= cyc + 1;
		tx_ready <= !stall || (cyc % 3 != 0);
	end

	always @(posedge clk) begin
		if ((tx_valid && tx_ready) === 1'b1) begin
			got.push_back(tx_data);
			if (tx_last === 1'b1) last_pos = got.size();
		end
	end

	//--------------------
	// Frame source
	//--------------------
	function automatic logic [31:0] fcs(input logic [7:0] m[$]);
		logic [31:0] c;
		c = `LTC_CRC_INIT;
		foreach (m[i]) begin
			c ^= {24'h0000_00, m[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ `LTC_CRC_POLY : c >> 1;
		end
		return ~c;
	endfunction : fcs

	// Control: header, one attribute header, payload; data: payload only
	task automatic build(input bit c, input logic [7:0] b0,
		input logic [7:0] b1, input bit mb, input bit hb,
		input logic [15:0] ven, input logic [63:0] hf, input logic [15:0] ty,
		input int n, input int adj, output logic [7:0] m[$]);
		logic [15:0] len;
		logic [9:0] al;
		len = 16'(18 + n + adj);
		al = 10'(6 + n);
		m = {};
		if (c) begin
			m = {b0, b1, len[15:8], len[7:0]};
			for (int i = 7; i >= 0; i--) m.push_back(hf[i*8+:8]);
			m.push_back({mb, hb, 4'h0, al[9:8]});
			m = {m, al[7:0], ven[15:8], ven[7:0], ty[15:8], ty[7:0]};
		end
		for (int i = 0; i < n; i++) m.push_back(8'h10 + 8'(i));
	endtask : build

	task automatic send(input logic [7:0] m[$], input bit bad);
		logic [31:0] f;
		f = fcs(m) ^ 32'(bad);
		for (int i = 0; i < 4; i++) m.push_back(f[i*8+:8]);
		foreach (m[i]) begin
			rx_data = m[i];
			rx_valid = 1'b1;
			rx_last = (i == m.size() - 1);
			@(negedge clk);
		end
		{rx_valid, rx_last} = '0;
		rx_data = ~rx_data;
	endtask : send
endmodule : ltc_peer
`default_nettype wire

// ==== testbench/tb.sv ====
// Testbench of the tunnel framer and checker
`timescale 1ns/10ps
`default_nettype none

module tb;
	localparam logic [15:0] KV = 16'h0BEE; // Arbitrary vendor code
	localparam logic [63:0] HF = 64'h0102_0304_A5B6_C7D8;
	localparam logic [15:0] TY = 16'h0007;
	localparam logic [15:0] PS = 16'h1234;
	typedef struct {
		bit c;
		logic [7:0] b0, b1;
		bit m, h;
		logic [15:0] v;
		int cm;
		bit au, ve, ok, cs, hd;
		int av;
	} ltc_row_type;
	logic CLK, RST_N, TX_START, TX_IS_CTRL, TX_CSUM_EN, TX_AVP_EN, TX_AVP_M;
	logic TX_BUSY, TX_IN_LAST, TX_IN_VALID, TX_IN_READY, TX_OUT_LAST;
	logic TX_OUT_VALID, TX_OUT_READY, TX_CSUM_VALID, RX_LAST, RX_VALID;
	logic RX_IS_CTRL, RX_AUTH_ACTIVE, RX_DATA_VERIFY, RX_HDR_VALID;
	logic RX_AVP_VALID, RX_AVP_M, RX_AVP_DROP, RX_TEARDOWN, RX_DONE, RX_OK;
	logic RX_BAD_CRC, RX_BAD_CSUM, RX_BAD_HDR, RX_BAD_LEN;
	logic [7:0] TX_IN_DATA, TX_OUT_DATA, RX_DATA;
	logic [15:0] TX_AVP_VENDOR, TX_AVP_TYPE, TX_NS, TX_NR, TX_PAYLOAD_LEN;
	logic [15:0] TX_PSEUDO_SUM, TX_CSUM, RX_CSUM_FIELD, RX_PSEUDO_SUM, RX_NS;
	logic [15:0] RX_NR, RX_AVP_VENDOR, RX_AVP_TYPE, tcs;
	logic [31:0] TX_CCID, RX_CCID;
	logic [32:0] sm;
	logic [7:0] msg[$];
	int sa, hv, cyc, bad_count, n_compared;
	ltc_row_type r;
	ltc_row_type rows[16] = '{
		'{1, 8'hC8, 8'h03, 1, 0, 16'h0000, 0, 0, 0, 1, 0, 0, 1},
		'{1, 8'hFF, 8'hF3, 0, 0, 16'h0000, 0, 0, 0, 1, 0, 0, 1},
		'{1, 8'hC8, 8'h03, 0, 0, 16'h0000, 1, 0, 0, 0, 1, 0, 1},
		'{1, 8'hC8, 8'h03, 0, 0, 16'h0000, 1, 1, 0, 1, 0, 0, 1},
		'{1, 8'hC8, 8'h03, 0, 0, 16'h0000, 2, 0, 0, 0, 1, 0, 1},
		'{1, 8'hC8, 8'h03, 0, 0, 16'h1234, 0, 0, 0, 1, 0, 0, 2},
		'{1, 8'hC8, 8'h03, 1, 0, 16'h1234, 0, 0, 0, 1, 0, 0, 3},
		'{1, 8'hC8, 8'h03, 0, 1, 16'h0000, 0, 0, 0, 1, 0, 0, 2},
		'{1, 8'hC8, 8'h03, 0, 0, KV, 0, 0, 0, 1, 0, 0, 1},
		'{1, 8'h48, 8'h03, 0, 0, 16'h0000, 0, 0, 0, 0, 0, 1, 0},
		'{1, 8'h88, 8'h03, 0, 0, 16'h0000, 0, 0, 0, 0, 0, 1, 0},
		'{1, 8'hC0, 8'h03, 0, 0, 16'h0000, 0, 0, 0, 0, 0, 1, 0},
		'{1, 8'hC8, 8'h02, 0, 0, 16'h0000, 0, 0, 0, 0, 0, 1, 0},
		'{0, 8'h00, 8'h00, 0, 0, 16'h0000, 2, 0, 0, 1, 0, 0, 0},
		'{0, 8'h00, 8'h00, 0, 0, 16'h0000, 2, 0, 1, 0, 1, 0, 0},
		'{0, 8'h00, 8'h00, 0, 0, 16'h0000, 1, 0, 1, 1, 0, 0, 0}
	};

	ltc_host_framer #(.KNOWN_VENDOR(KV)) i_ltc_host_framer (.CLK, .RST_N,
		.TX_START, .TX_IS_CTRL, .TX_CSUM_EN, .TX_AVP_EN, .TX_AVP_M,
		.TX_AVP_VENDOR, .TX_AVP_TYPE, .TX_CCID, .TX_NS, .TX_NR,
		.TX_PAYLOAD_LEN, .TX_PSEUDO_SUM, .TX_BUSY, .TX_IN_DATA, .TX_IN_LAST,
		.TX_IN_VALID, .TX_IN_READY, .TX_OUT_DATA, .TX_OUT_LAST, .TX_OUT_VALID,
		.TX_OUT_READY, .TX_CSUM, .TX_CSUM_VALID, .RX_DATA, .RX_LAST, .RX_VALID,
		.RX_IS_CTRL, .RX_CSUM_FIELD, .RX_PSEUDO_SUM, .RX_AUTH_ACTIVE,
		.RX_DATA_VERIFY, .RX_CCID, .RX_NS, .RX_NR, .RX_HDR_VALID, .RX_AVP_VALID,
		.RX_AVP_M, .RX_AVP_VENDOR, .RX_AVP_TYPE, .RX_AVP_DROP, .RX_TEARDOWN,
		.RX_DONE, .RX_OK, .RX_BAD_CRC, .RX_BAD_CSUM, .RX_BAD_HDR, .RX_BAD_LEN);

	ltc_peer i_ltc_peer (.clk(CLK), .tx_data(TX_OUT_DATA),
		.tx_valid(TX_OUT_VALID), .tx_last(TX_OUT_LAST), .tx_ready(TX_OUT_READY),
		.rx_data(RX_DATA), .rx_valid(RX_VALID), .rx_last(RX_LAST));

	//--------------------
	// Checking
	//--------------------
	task automatic complete_run();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string s, input logic [63:0] e,
		input logic [63:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	// Checksum field over pseudo sum and message, zero sent as all ones
	function automatic logic [15:0] csf(input logic [7:0] m[$]);
		logic [16:0] a;
		a = {1'b0, PS};
		for (int i = 0; i < m.size(); i += 2)
			a = {1'b0, a[15:0]} + 17'(a[16])
				+ {1'b0, m[i], i + 1 < m.size() ? m[i + 1] : 8'h00};
		a = {1'b0, a[15:0]} + 17'(a[16]);
		return ~a[15:0] == 16'h0000 ? 16'hFFFF : ~a[15:0];
	endfunction : csf

	always @(posedge CLK) begin
		if (RX_AVP_VALID === 1'b1) sa = 1;
		if (RX_AVP_DROP === 1'b1) sa = 2;
		if (RX_TEARDOWN === 1'b1) sa = 3;
		if (RX_HDR_VALID === 1'b1) hv = 1;
		if ((RX_AVP_VALID | RX_AVP_DROP | RX_TEARDOWN) === 1'b1)
			sm = {RX_AVP_M, RX_AVP_VENDOR, RX_AVP_TYPE};
		if (TX_CSUM_VALID === 1'b1) tcs = TX_CSUM;
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end

	//--------------------
	// Stimulus
	//--------------------
	task automatic rx_frame(input ltc_row_type q, input bit bad);
		RX_IS_CTRL = q.c;
		RX_AUTH_ACTIVE = q.au;
		RX_DATA_VERIFY = q.ve;
		RX_CSUM_FIELD = q.cm == 1 ? 16'h0000 : csf(msg) ^ 16'(q.cm == 2);
		sa = 0;
		hv = 0;
		i_ltc_peer.send(msg, bad);
		for (int k = 0; k < 8 && RX_DONE !== 1'b1; k++) @(negedge CLK);
		chk("rx done", 1, RX_DONE);
	endtask : rx_frame

	task automatic tx(input bit c, input bit e, input int n);
		logic [7:0] g[$];
		{TX_IS_CTRL, TX_AVP_EN, TX_CSUM_EN} = {c, c, e};
		TX_PAYLOAD_LEN = 16'(n);
		tcs = 16'h5A5A;
		i_ltc_peer.got.delete();
		i_ltc_peer.build(c, 8'hC8, 8'h03, 1, 0, 16'h0000, HF, TY, n, 0, msg);
		for (int i = 0; i <= n; i++) begin
			if (i == (n < 8 ? n : 8)) begin
				if (n >= 8) chk("fifo full", 0, TX_IN_READY);
				TX_IN_VALID = 0;
				TX_START = 1;
				@(negedge CLK);
				TX_START = 0;
			end
			if (i < n) begin
				while (TX_IN_READY !== 1'b1) begin
					TX_IN_VALID = 0;
					@(negedge CLK);
				end
				TX_IN_VALID = 1;
				TX_IN_DATA = msg[msg.size() - n + i];
				TX_IN_LAST = (i == n - 1);
				@(negedge CLK);
			end
		end
		TX_IN_VALID = 0;
		for (int k = 0; k < 400 && TX_BUSY !== 1'b0; k++) @(negedge CLK);
		// Last byte may still wait out one sink stall
		repeat (3) @(negedge CLK);
		g = i_ltc_peer.got;
		chk("tx count", msg.size() + 4, g.size());
		chk("tx last", msg.size() + 4, i_ltc_peer.last_pos);
		for (int i = 0; i < msg.size() && i < g.size(); i++)
			chk("tx byte", msg[i], g[i]);
		if (g.size() == msg.size() + 4)
			chk("tx fcs", i_ltc_peer.fcs(msg), {g[$], g[$-1], g[$-2], g[$-3]});
		chk("tx csum", c | e ? csf(msg) : 16'h0000, tcs);
	endtask : tx

	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end

	initial begin
		{RST_N, TX_START, TX_IS_CTRL, TX_CSUM_EN, TX_AVP_EN, TX_IN_VALID} = '0;
		{TX_IN_LAST, RX_IS_CTRL, RX_AUTH_ACTIVE, RX_DATA_VERIFY} = '0;
		{TX_AVP_M, TX_AVP_VENDOR, TX_AVP_TYPE} = {1'b1, 16'h0000, TY};
		{TX_CCID, TX_NS, TX_NR, TX_PSEUDO_SUM, RX_PSEUDO_SUM} = {HF, PS, PS};
		{TX_PAYLOAD_LEN, TX_IN_DATA, RX_CSUM_FIELD} = '0;
		repeat (4) @(negedge CLK);
		chk("reset", 0, {TX_BUSY, TX_IN_READY, TX_OUT_VALID, RX_DONE, RX_OK});
		RST_N = 1'b1;
		@(negedge CLK);
		chk("ready after reset", 1, TX_IN_READY);
		foreach (rows[k]) begin
			r = rows[k];
			i_ltc_peer.build(r.c, r.b0, r.b1, r.m, r.h, r.v, HF, TY, 3, 0, msg);
			rx_frame(r, 0);
			chk("rx ok", r.ok, RX_OK);
			chk("rx csum", r.cs, RX_BAD_CSUM);
			chk("rx hdr", r.hd, RX_BAD_HDR);
			chk("rx crc", 0, RX_BAD_CRC);
			chk("rx hdr valid", r.c, hv);
			if (r.c && !r.hd) chk("rx ids", HF, {RX_CCID, RX_NS, RX_NR});
			if (!r.hd) chk("avp kind", r.av, sa);
			if (r.av != 0) chk("avp fields", {r.m, r.v, TY}, sm);
		end
		r = rows[0];
		i_ltc_peer.build(1, 8'hC8, 8'h03, 0, 0, 16'h0000, HF, TY, 4, 0, msg);
		rx_frame(r, 1);
		chk("bad crc", 1, RX_BAD_CRC);
		i_ltc_peer.build(1, 8'hC8, 8'h03, 0, 0, 16'h0000, HF, TY, 4, 1, msg);
		rx_frame(r, 0);
		chk("bad length", 1, RX_BAD_LEN);
		i_ltc_peer.stall = 1;
		tx(1, 0, 3);
		i_ltc_peer.stall = 0;
		tx(0, 0, 12);
		tx(0, 1, 5);
		i_ltc_peer.stall = 1;
		tx(1, 1, 9);
		complete_run();
	end
endmodule : tb
`default_nettype wire
